// >>> src/bc_seq_map.svh
// offsets, field positions, codes and reset values of the sequencer
// assumes an APB slave with 32-bit data and byte addresses
`ifndef BC_SEQ_MAP_SVH
`define BC_SEQ_MAP_SVH
// register byte addresses
`define SEQ_CTRL_ADDR 8'h00
`define SEQ_PTR_INIT_ADDR 8'h04
`define SEQ_PTR_ADDR 8'h08
`define SEQ_GPF_ADDR 8'h0C
`define SEQ_IST1_ADDR 8'h10
`define SEQ_IST2_ADDR 8'h14
`define SEQ_IEN1_ADDR 8'h18
`define SEQ_IEN2_ADDR 8'h1C
`define SEQ_COND_ADDR 8'h20
// control bits
`define SEQ_CTRL_START_BIT 0
`define SEQ_CTRL_STOP_BIT 1
// status 1 fields
`define SEQ_IST1_TRAP_BIT 0
`define SEQ_IST1_PAR_BIT 1
`define SEQ_IST1_STK_BIT 2
// status 2 user request field
`define SEQ_IST2_REQ_LO 2
`define SEQ_IST2_REQ_HI 5
// op code word layout
`define SEQ_OP_PAR_BIT 15
`define SEQ_OP_CODE_HI 14
`define SEQ_OP_CODE_LO 10
`define SEQ_OP_FIX_HI 9
`define SEQ_OP_FIX_LO 5
`define SEQ_OP_FIX_PAT 5'h0A
`define SEQ_OP_SENSE_BIT 4
// op codes
`define SEQ_OPC_EXEC 5'h01
`define SEQ_OPC_BRANCH 5'h02
`define SEQ_OPC_CALL 5'h03
`define SEQ_OPC_RETURN 5'h04
`define SEQ_OPC_IRQ 5'h06
`define SEQ_OPC_FLAG 5'h0C
// stack and step
`define SEQ_STACK_DEPTH 3'h4
`define SEQ_STEP 16'h0002
`define SEQ_PTR_RESET 16'h0000
`endif

// >>> src/bc_seq_pkg.sv
// types of the message sequence instruction unit
// assumes nothing beyond the map header
package bc_seq_pkg;
    // gray coded along fetch, parameter, execute, wait
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH_OP = 3'h1,
        ST_FETCH_PRM = 3'h3,
        ST_EXEC = 3'h2,
        ST_WAIT_MSG = 3'h6,
        ST_HALT = 3'h7
    } seq_state_t;
endpackage

// >>> src/bc_sequence_instruction_unit.sv
// fetch, check and execute unit for the bus controller sequence program
// assumes a shared memory with a read strobe held until acknowledged,
// a message engine that pulses done, and an APB master for registers
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "bc_seq_map.svh"

module bc_sequence_instruction_unit
    import bc_seq_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic MEM_RD_OUT,
    output logic [15:0] MEM_ADDR_OUT,
    input wire logic [15:0] MEM_DATA_IN,
    input wire logic MEM_ACK_IN,
    output logic MSG_START_OUT,
    output logic [15:0] MSG_ADDR_OUT,
    input wire logic MSG_DONE_IN,
    input wire logic [7:0] MSG_COND_IN,
    output logic RUNNING_OUT,
    output logic IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    seq_state_t state_r; // sequencer state
    logic [15:0] ptr_r; // instruction list pointer
    logic [15:0] op_r; // latched op code word
    logic [15:0] prm_r; // latched parameter word
    logic [7:0] gpf_r; // general purpose flags
    logic [15:0] stk_r [0:3]; // return stack
    logic [2:0] sp_r; // stack fill count
    logic [2:0] ist1_r; // trap, parity, stack status
    logic [5:0] ist2_r; // user request status, bits 5-2 used
    logic [2:0] ien1_r; // enables for status 1
    logic [5:0] ien2_r; // enables for status 2
    logic pready_r; // apb ready
    logic [31:0] prdata_r; // apb read data
    logic pslverr_r; // apb error
    logic mem_rd_r; // memory read strobe
    logic msg_start_r; // message start pulse
    logic irq_r; // interrupt level
    logic [15:0] cond_vec; // all sixteen condition codes
    logic cond_ok; // condition test passes
    logic word_bad; // fetched op code word illegal
    logic par_bad; // fetched op code word even parity
    logic wr_en; // apb write takes effect
    logic start_wr; // host start request
    logic stop_wr; // host stop request
    logic [4:0] opc; // op field of latched word

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true for op codes this unit executes
    function automatic logic op_known(input logic [4:0] c);
        op_known = (c == `SEQ_OPC_EXEC) || (c == `SEQ_OPC_BRANCH) || (c == `SEQ_OPC_CALL) ||
                   (c == `SEQ_OPC_RETURN) || (c == `SEQ_OPC_IRQ) || (c == `SEQ_OPC_FLAG);
    endfunction

    // apb write or read hits an address
    function automatic logic hit(input logic [7:0] a);
        hit = (PADDR_IN == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode of fetched word and condition

    // low eight are flags, high eight come from the last message
    assign cond_vec = {MSG_COND_IN, gpf_r};
    assign opc = op_r[`SEQ_OP_CODE_HI:`SEQ_OP_CODE_LO];
    // selector picks a code, sense bit gives the level that passes
    assign cond_ok = (cond_vec[op_r[3:0]] == op_r[`SEQ_OP_SENSE_BIT]);
    // odd parity over all sixteen bits is the only legal form
    assign par_bad = ~(^MEM_DATA_IN);
    assign word_bad = par_bad || !op_known(MEM_DATA_IN[`SEQ_OP_CODE_HI:`SEQ_OP_CODE_LO]) ||
                      (MEM_DATA_IN[`SEQ_OP_FIX_HI:`SEQ_OP_FIX_LO] != `SEQ_OP_FIX_PAT);
    assign wr_en = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN;
    assign start_wr = wr_en && hit(`SEQ_CTRL_ADDR) && PWDATA_IN[`SEQ_CTRL_START_BIT];
    assign stop_wr = wr_en && hit(`SEQ_CTRL_ADDR) && PWDATA_IN[`SEQ_CTRL_STOP_BIT];

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, read data registered with ready
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= PSEL_IN && PENABLE_IN && !pready_r;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            if (PSEL_IN && PENABLE_IN && !pready_r) begin
                case (PADDR_IN)
                    `SEQ_CTRL_ADDR: prdata_r <= {31'h0, state_r != ST_IDLE && state_r != ST_HALT};
                    `SEQ_PTR_INIT_ADDR, `SEQ_PTR_ADDR: prdata_r <= {16'h0, ptr_r};
                    `SEQ_GPF_ADDR: prdata_r <= {24'h0, gpf_r};
                    `SEQ_IST1_ADDR: prdata_r <= {29'h0, ist1_r};
                    `SEQ_IST2_ADDR: prdata_r <= {26'h0, ist2_r};
                    `SEQ_IEN1_ADDR: prdata_r <= {29'h0, ien1_r};
                    `SEQ_IEN2_ADDR: prdata_r <= {26'h0, ien2_r};
                    `SEQ_COND_ADDR: prdata_r <= {16'h0, cond_vec};
                    // unmapped address answers with an error
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt enables, host written
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            ien1_r <= 3'h0;
            ien2_r <= 6'h0;
        end else if (wr_en && hit(`SEQ_IEN1_ADDR)) begin
            ien1_r <= PWDATA_IN[2:0];
        end else if (wr_en && hit(`SEQ_IEN2_ADDR)) begin
            ien2_r <= {PWDATA_IN[5:2], 2'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state, pointer and stack
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            state_r <= ST_IDLE;
            ptr_r <= `SEQ_PTR_RESET;
            op_r <= 16'h0;
            prm_r <= 16'h0;
            sp_r <= 3'h0;
            mem_rd_r <= 1'b0;
            msg_start_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                stk_r[i] <= 16'h0;
            end
        end else begin
            msg_start_r <= 1'b0;
            case (state_r)
                ST_IDLE, ST_HALT: begin
                    // pointer only loadable while stopped
                    if (wr_en && hit(`SEQ_PTR_INIT_ADDR)) begin
                        ptr_r <= PWDATA_IN[15:0];
                    end
                    if (start_wr) begin
                        state_r <= ST_FETCH_OP;
                        mem_rd_r <= 1'b1;
                    end
                end
                ST_FETCH_OP: begin
                    if (MEM_ACK_IN) begin
                        op_r <= MEM_DATA_IN;
                        if (word_bad) begin
                            // stop at once, the parameter is never fetched
                            mem_rd_r <= 1'b0;
                            state_r <= ST_HALT;
                        end else begin
                            state_r <= ST_FETCH_PRM;
                        end
                    end
                end
                ST_FETCH_PRM: begin
                    if (MEM_ACK_IN) begin
                        prm_r <= MEM_DATA_IN;
                        mem_rd_r <= 1'b0;
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    // default is the next two-word entry
                    ptr_r <= ptr_r + `SEQ_STEP;
                    state_r <= ST_FETCH_OP;
                    mem_rd_r <= 1'b1;
                    if (cond_ok) begin
                        case (opc)
                            `SEQ_OPC_EXEC: begin
                                msg_start_r <= 1'b1;
                                mem_rd_r <= 1'b0;
                                state_r <= ST_WAIT_MSG;
                            end
                            `SEQ_OPC_BRANCH: ptr_r <= prm_r;
                            `SEQ_OPC_CALL: begin
                                if (sp_r == `SEQ_STACK_DEPTH) begin
                                    // overrun halts rather than lose a return point
                                    mem_rd_r <= 1'b0;
                                    state_r <= ST_HALT;
                                end else begin
                                    stk_r[sp_r[1:0]] <= ptr_r + `SEQ_STEP;
                                    sp_r <= sp_r + 3'h1;
                                    ptr_r <= prm_r;
                                end
                            end
                            `SEQ_OPC_RETURN: begin
                                if (sp_r == 3'h0) begin
                                    mem_rd_r <= 1'b0;
                                    state_r <= ST_HALT;
                                end else begin
                                    ptr_r <= stk_r[sp_r[1:0] - 2'h1];
                                    sp_r <= sp_r - 3'h1;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ST_WAIT_MSG: begin
                    // message engine owns the bus until done
                    if (MSG_DONE_IN) begin
                        state_r <= ST_FETCH_OP;
                        mem_rd_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            if (stop_wr) begin
                state_r <= ST_IDLE;
                mem_rd_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general purpose flags: host writes directly, flag op sets, clears, toggles
    // parameter bits 7-0 set, bits 15-8 clear, both together toggle
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            gpf_r <= 8'h0;
        end else if (state_r == ST_EXEC && opc == `SEQ_OPC_FLAG) begin
            // unconditional, condition field is ignored
            gpf_r <= (gpf_r & ~prm_r[15:8] | prm_r[7:0]) & ~(prm_r[15:8] & prm_r[7:0]) |
                     (~gpf_r & prm_r[15:8] & prm_r[7:0]);
        end else if (wr_en && hit(`SEQ_GPF_ADDR)) begin
            gpf_r <= PWDATA_IN[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            ist1_r <= 3'h0;
            ist2_r <= 6'h0;
        end else begin
            ist1_r <= ist1_r & ~((wr_en && hit(`SEQ_IST1_ADDR)) ? PWDATA_IN[2:0] : 3'h0);
            ist2_r <= ist2_r & ~((wr_en && hit(`SEQ_IST2_ADDR)) ? PWDATA_IN[5:0] : 6'h0);
            if (state_r == ST_FETCH_OP && MEM_ACK_IN && word_bad) begin
                if (ien1_r[`SEQ_IST1_TRAP_BIT]) begin
                    ist1_r[`SEQ_IST1_TRAP_BIT] <= 1'b1;
                end
                if (par_bad && ien1_r[`SEQ_IST1_PAR_BIT]) begin
                    ist1_r[`SEQ_IST1_PAR_BIT] <= 1'b1;
                end
            end
            if (state_r == ST_EXEC && cond_ok && ien1_r[`SEQ_IST1_STK_BIT] &&
                ((opc == `SEQ_OPC_CALL && sp_r == `SEQ_STACK_DEPTH) ||
                 (opc == `SEQ_OPC_RETURN && sp_r == 3'h0))) begin
                ist1_r[`SEQ_IST1_STK_BIT] <= 1'b1;
            end
            // zero pattern sets nothing, upper parameter bits unused
            if (state_r == ST_EXEC && cond_ok && opc == `SEQ_OPC_IRQ) begin
                ist2_r <= ist2_r & ~((wr_en && hit(`SEQ_IST2_ADDR)) ? PWDATA_IN[5:0] : 6'h0) |
                          ({prm_r[3:0], 2'h0} & ien2_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt level from enabled status
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist1_r & ien1_r) || |(ist2_r & ien2_r);
        end
    end

    assign PRDATA_OUT = prdata_r;
    assign PREADY_OUT = pready_r;
    assign PSLVERR_OUT = pslverr_r;
    assign MEM_RD_OUT = mem_rd_r;
    assign MEM_ADDR_OUT = (state_r == ST_FETCH_PRM) ? ptr_r + 16'h1 : ptr_r;
    assign MSG_START_OUT = msg_start_r;
    assign MSG_ADDR_OUT = prm_r;
    assign RUNNING_OUT = (state_r != ST_IDLE) && (state_r != ST_HALT);
    assign IRQ_OUT = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic ex_ok;
    assign ex_ok = state_r == ST_EXEC && cond_ok;

    AST_PAR_HALT: assert property (
        state_r == ST_FETCH_OP && MEM_ACK_IN && !(^MEM_DATA_IN) && !stop_wr |=> state_r == ST_HALT)
        else $error("even parity word did not halt");
    AST_PAT_HALT: assert property (
        state_r == ST_FETCH_OP && MEM_ACK_IN && MEM_DATA_IN[9:5] != 5'h0A && !stop_wr
        |=> state_r == ST_HALT ##1 !mem_rd_r)
        else $error("bad fixed pattern did not halt");
    AST_TRAP: assert property (
        state_r == ST_FETCH_OP && MEM_ACK_IN && word_bad && ien1_r[0] |=> ist1_r[0])
        else $error("trap status not set");
    AST_PAR_INT: assert property (
        state_r == ST_FETCH_OP && MEM_ACK_IN && par_bad && ien1_r[1] |=> ist1_r[1] && ist1_r[0] == ien1_r[0])
        else $error("parity status not set");
    AST_EXEC: assert property (
        ex_ok && opc == 5'h01 && !stop_wr |=> MSG_START_OUT && MSG_ADDR_OUT == $past(prm_r) ##1 !MSG_START_OUT)
        else $error("message not started");
    AST_BRANCH: assert property (
        ex_ok && opc == 5'h02 && !stop_wr |=> ptr_r == $past(prm_r) && state_r == ST_FETCH_OP)
        else $error("branch target wrong");
    AST_CALL: assert property (
        ex_ok && opc == 5'h03 && sp_r < 3'h4 |=> ptr_r == $past(prm_r) && sp_r == $past(sp_r) + 3'h1)
        else $error("call did not push and branch");
    AST_RETURN: assert property (
        ex_ok && opc == 5'h04 && sp_r != 3'h0 |=> ptr_r == stk_r[sp_r[1:0]] && sp_r == $past(sp_r) - 3'h1)
        else $error("return address wrong");
    AST_REQ: assert property (
        ex_ok && opc == 5'h06 && ien2_r == 6'h3C |=> (ist2_r[5:2] & $past(prm_r[3:0])) == $past(prm_r[3:0]))
        else $error("request bits not copied");
    AST_REQ_ZERO: assert property (
        ex_ok && opc == 5'h06 && prm_r[3:0] == 4'h0 && !wr_en |=> $stable(ist2_r))
        else $error("zero request changed status");
    AST_STEP: assert property (
        state_r == ST_EXEC && (!cond_ok || opc inside {5'h01, 5'h06, 5'h0C}) && !stop_wr
        |=> ptr_r == $past(ptr_r) + 16'h2)
        else $error("pointer did not advance by two");
    AST_STACK_ERR: assert property (
        ex_ok && opc == 5'h04 && sp_r == 3'h0 && ien1_r[2] |=> ist1_r[2] && state_r inside {ST_HALT, ST_IDLE})
        else $error("underrun not flagged");
    AST_FLAG: assert property (
        state_r == ST_EXEC && opc == 5'h0C |=> gpf_r == (($past(gpf_r) & ~$past(prm_r[15:8]) & ~$past(prm_r[7:0])) |
        ($past(prm_r[7:0]) & ~$past(prm_r[15:8])) | (~$past(gpf_r) & $past(prm_r[7:0]) & $past(prm_r[15:8]))))
        else $error("flag update wrong");

    COV_EXEC: cover property (ex_ok && opc == 5'h01 ##[1:50] MSG_DONE_IN);
    COV_CALL_RET: cover property (ex_ok && opc == 5'h03 ##[2:100] ex_ok && opc == 5'h04);
    COV_TRAP: cover property (state_r == ST_FETCH_OP && MEM_ACK_IN && word_bad);

endmodule

// >>> sim/seq_host_model.sv
// model of the program memory and of the message engine
// assumes one clock; the read strobe is held until acknowledged
`timescale 1ns/1ps
module seq_host_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rd_in,
    input wire logic [15:0] addr_in,
    output logic [15:0] data_out,
    output logic ack_out,
    input wire logic start_in,
    input wire logic [15:0] msg_addr_in,
    output logic done_out,
    output logic [7:0] cond_out
);
    logic [15:0] mem [0:63]; // program words, written by the bench
    logic [1:0] wait_r; // cycles before the next ack
    logic [1:0] lat_r; // latency rotates so prompt and slow answers mix
    logic [3:0] busy_r; // message time left
    int n_msgs; // messages started
    logic [15:0] last_msg_r; // block address of the last message
    assign cond_out = 8'h01; // result code 8 true, 9 to F false
    ////////////////////////////////////////////////////////////////
    // memory: data valid only with ack, garbage otherwise
    always_ff @(posedge clk_in) begin
        ack_out <= 1'b0;
        if (!rst_n_in) begin
            wait_r <= 2'h0;
            lat_r <= 2'h0;
            data_out <= 16'h5A5A;
        end else if (rd_in && !ack_out && wait_r == 2'h0) begin
            ack_out <= 1'b1;
            data_out <= mem[addr_in[5:0]];
            wait_r <= lat_r;
            lat_r <= lat_r + 2'h1;
        end else begin
            // stale data is inverted so a late sample cannot pass
            wait_r <= (rd_in && !ack_out && wait_r != 2'h0) ? wait_r - 2'h1 : wait_r;
            data_out <= ~data_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    // message engine: fixed run time, then one done pulse
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        if (!rst_n_in) begin
            busy_r <= 4'h0;
            n_msgs <= 0;
        end else if (start_in) begin
            busy_r <= 4'h6;
            n_msgs <= n_msgs + 1;
            last_msg_r <= msg_addr_in;
        end else if (busy_r != 4'h0) begin
            busy_r <= busy_r - 4'h1;
            done_out <= (busy_r == 4'h1);
        end
    end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the sequence instruction unit
// assumes the design sources and the host model are compiled first
`timescale 1ns/1ps
`include "bc_seq_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
    typedef struct {
        logic [15:0] w0, p0, w1, p1, w2, p2, ptr;
        logic [7:0] ist1, ist2, gpf;
        int msgs;
    } row_t;
    localparam logic [4:0] T = 5'h00; // general flag 0 clear: true
    localparam logic [4:0] F = 5'h10; // general flag 0 set: false
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic pready, pslverr, mem_rd, mem_ack, msg_start, msg_done, running, irq, err;
    logic [15:0] mem_addr, mem_data, msg_addr;
    logic [7:0] msg_cond;
    int n_errors = 0, tests_run = 0, cyc = 0, n0;
    row_t rows [14];
    always #25 clk = ~clk;
    bc_sequence_instruction_unit DUT (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MEM_RD_OUT(mem_rd),
        .MEM_ADDR_OUT(mem_addr), .MEM_DATA_IN(mem_data), .MEM_ACK_IN(mem_ack),
        .MSG_START_OUT(msg_start), .MSG_ADDR_OUT(msg_addr), .MSG_DONE_IN(msg_done),
        .MSG_COND_IN(msg_cond), .RUNNING_OUT(running), .IRQ_OUT(irq));
    seq_host_model m (.clk_in(clk), .rst_n_in(rst_n), .rd_in(mem_rd), .addr_in(mem_addr),
        .data_out(mem_data), .ack_out(mem_ack), .start_in(msg_start), .msg_addr_in(msg_addr),
        .done_out(msg_done), .cond_out(msg_cond));
    ////////////////////////////////////////////////////////////////
    // op word with odd parity over all sixteen bits
    function automatic logic [15:0] op(input logic [4:0] code, input logic [4:0] cond);
        logic [14:0] low;
        low = {code, 5'h0A, cond};
        return {~^low, low};
    endfunction
    // one apb transfer; read data lands in v, error flag in err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // ready is looked at mid-cycle where it has settled; the request
        // still stands at the next rising edge, where the slave takes it
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        v = prdata;
        err = pslverr;
        @(posedge clk);
        if (n >= 20) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // program at 0, 2 and 16; every other word is an illegal zero
    task automatic load(input row_t r);
        for (int i = 0; i < 64; i++) begin
            m.mem[i] = 16'h0000;
        end
        m.mem[0] = r.w0;
        m.mem[1] = r.p0;
        m.mem[2] = r.w1;
        m.mem[3] = r.p1;
        m.mem[16] = r.w2;
        m.mem[17] = r.p2;
    endtask
    // clear status, start at s and wait for the halt
    task automatic run_prog(input logic [15:0] s);
        int n;
        n = 0;
        apb(1'b1, `SEQ_IST1_ADDR, 32'h7);
        apb(1'b1, `SEQ_IST2_ADDR, 32'h3C);
        apb(1'b1, `SEQ_GPF_ADDR, 32'h0);
        apb(1'b1, `SEQ_PTR_INIT_ADDR, {16'h0, s});
        n0 = m.n_msgs;
        apb(1'b1, `SEQ_CTRL_ADDR, 32'h1);
        // looked at mid-cycle, so the start just taken is already visible
        do begin
            @(negedge clk);
            n++;
        end while (running === 1'b1 && n < 500);
        if (n >= 500) n_errors++;
    endtask
    task automatic check(input row_t r);
        apb(1'b0, `SEQ_PTR_ADDR, 32'h0);
        `CHK(v[15:0], r.ptr)
        apb(1'b0, `SEQ_IST1_ADDR, 32'h0);
        `CHK(v[7:0], r.ist1)
        apb(1'b0, `SEQ_IST2_ADDR, 32'h0);
        `CHK(v[7:0], r.ist2)
        apb(1'b0, `SEQ_GPF_ADDR, 32'h0);
        `CHK(v[7:0], r.gpf)
        `CHK(m.n_msgs - n0, r.msgs)
        if (r.msgs > 0) `CHK(m.last_msg_r, 16'h0028)
        `CHK(irq, 1'((r.ist1 | r.ist2) != 8'h00))
        `CHK(running, 1'b0)
    endtask
    task automatic finish_test;
        $display("tests run %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{op(`SEQ_OPC_EXEC, T), 16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'h00, 1};
        rows[1] = '{op(`SEQ_OPC_EXEC, F), 16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'h00, 0};
        rows[2] = '{op(`SEQ_OPC_BRANCH, T), 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0010, 8'h03, 8'h00, 8'h00, 0};
        rows[3] = '{op(`SEQ_OPC_BRANCH, 5'h18), 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0010, 8'h03, 8'h00, 8'h00, 0};
        rows[4] = '{op(`SEQ_OPC_BRANCH, 5'h19), 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'h00, 0};
        rows[5] = '{op(`SEQ_OPC_CALL, T), 16'h0010, 16'h0, 16'h0, op(`SEQ_OPC_RETURN, T), 16'hFFFF, 16'h0002,
            8'h03, 8'h00, 8'h00, 0};
        rows[6] = '{op(`SEQ_OPC_RETURN, F), 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'h00, 0};
        rows[7] = '{op(`SEQ_OPC_IRQ, T), 16'hFFF5, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h14, 8'h00, 0};
        rows[8] = '{op(`SEQ_OPC_IRQ, T), 16'hFFF0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'h00, 0};
        rows[9] = '{op(`SEQ_OPC_FLAG, T), 16'h00A5, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0002, 8'h03, 8'h00, 8'hA5, 0};
        rows[10] = '{op(`SEQ_OPC_FLAG, T), 16'h00F0, op(`SEQ_OPC_FLAG, T), 16'hFF3C, 16'h0, 16'h0, 16'h0004,
            8'h03, 8'h00, 8'h0C, 0};
        rows[11] = '{op(`SEQ_OPC_EXEC, T) ^ 16'h8020, 16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0000,
            8'h01, 8'h00, 8'h00, 0};
        rows[12] = '{op(`SEQ_OPC_BRANCH, T) ^ 16'h8000, 16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0000,
            8'h03, 8'h00, 8'h00, 0};
        rows[13] = '{op(5'h07, T), 16'h0000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0000, 8'h01, 8'h00, 8'h00, 0};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `SEQ_PTR_ADDR, 32'h0);
        `CHK(v, 32'h0)
        apb(1'b1, `SEQ_IEN1_ADDR, 32'h7);
        apb(1'b1, `SEQ_IEN2_ADDR, 32'h3C);
        for (int i = 0; i < 14; i++) begin
            load(rows[i]);
            run_prog(16'h0000);
            check(rows[i]);
            $display("row %0d done", i);
        end
        // five nested calls from a host-chosen start overflow the stack;
        // the halt leaves the pointer one entry past the refused call
        load(rows[13]);
        for (int k = 0; k < 5; k++) begin
            m.mem[32 + 2 * k] = op(`SEQ_OPC_CALL, T);
            m.mem[33 + 2 * k] = 16'(34 + 2 * k);
        end
        run_prog(16'h0020);
        check('{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h002A, 8'h04, 8'h00, 8'h00, 0});
        $display("stack overflow test done");
        // trap with its interrupt disabled leaves no status
        apb(1'b1, `SEQ_IEN1_ADDR, 32'h0);
        run_prog(16'h0000);
        check('{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0000, 8'h00, 8'h00, 8'h00, 0});
        $display("masked trap test done");
        // a branch to itself runs until the host stops it
        m.mem[0] = op(`SEQ_OPC_BRANCH, T);
        m.mem[1] = 16'h0000;
        apb(1'b1, `SEQ_CTRL_ADDR, 32'h1);
        repeat (30) @(posedge clk);
        apb(1'b0, `SEQ_CTRL_ADDR, 32'h0);
        `CHK(v[0], 1'b1)
        apb(1'b0, `SEQ_COND_ADDR, 32'h0);
        `CHK(v[15:0], 16'h0100)
        apb(1'b1, `SEQ_CTRL_ADDR, 32'h2);
        @(negedge clk);
        `CHK(running, 1'b0)
        $display("host stop test done");
        apb(1'b0, 8'h3C, 32'h0);
        `CHK(err, 1'b1)
        $display("unmapped access test done");
        finish_test;
    end
endmodule
